// ---- hdl/wdt_pkg.sv ----
// What this block does
// R1: the source select bit of port mode 2 picks the mode register clock field when 0 and subclock/32 when 1.
// R2: a clock field code with its top bit at 0 picks the on-chip oscillator; the reset code of all ones picks clk/8192.
// R3: the other clock field codes with top bit 1 pick further prescaler taps, among them clk/1024, /2048 and /4096.
// R4: the module standby bit puts the watchdog in module standby at 0, releases it at 1, and resets to 1.
// R5: a 0 written to the standby bit while the watchdog is on is stored, but standby waits until the on bit is cleared.
// R6: the watchdog counter is an 8-bit up-counter that steps once per selected source clock tick.
// R7: counting starts only when the write-enable bit is 1 and one write puts 0 in the write inhibit and 1 in the on bit.
// R8: software needs two writes to the control/status register to turn the watchdog on from off.
// R9: the on bit comes out of reset as 1, so the counter runs with no software write.
// R10: a tick with the counter at FF overflows it and the internal reset request rises one base clock later.
// R11: the internal reset from an overflow stays asserted for 512 oscillator clock cycles.
// R12: a software write loads the counter and counting goes on from there, so overflow comes 1 to 256 ticks later.
// R13: in subactive mode counter and control registers work only with subclock/32 or oscillator as source, else halt.
// R14: in standby mode the counter runs only with the oscillator as source and halts otherwise.
// R15: reset gives all registers their initial values; active and sleep run normally; module standby halts the counter.
package wdt_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL  = 12'h000;
  localparam logic [11:0] OFS_COUNT = 12'h004;
  localparam logic [11:0] OFS_MODE  = 12'h008;
  localparam logic [11:0] OFS_CKSTP = 12'h00C;
  localparam logic [11:0] OFS_PMR   = 12'h010;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CSR_WE_BIT   = 7;
  localparam int CSR_INH_BIT  = 3;
  localparam int CSR_ON_BIT   = 2;
  localparam int CKSTP_WD_BIT = 2;
  localparam int PMR_SRC_BIT  = 2;
  localparam int CKS_TOP_BIT  = 3;

  // ----------------------------------------------------------------
  // reset values and write masks
  // ----------------------------------------------------------------
  localparam logic       CSR_ON_RST  = 1'h1;
  localparam logic       CSR_WE_RST  = 1'h0;
  localparam logic [3:0] MODE_CKS_RST = 4'hF;
  localparam logic [7:0] CKSTP_RST   = 8'hFF;
  localparam logic [7:0] CKSTP_WMASK = 8'h9F;
  localparam logic [7:0] PMR_RST     = 8'hD8;
  localparam logic [7:0] PMR_WMASK   = 8'h27;

  // ----------------------------------------------------------------
  // counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_MAX        = 8'hFF;
  localparam int         SUB_DIV_W      = 5;
  localparam int         PRESC_LSB_EXP  = 6;
  localparam int         PRESC_TAPS     = 8;
  localparam int         RST_OSC_CYCLES = 512;

endpackage

// ---- hdl/wd_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
module wd_prescaler
  import wdt_pkg::*;
#(
  parameter int LSB_EXP = PRESC_LSB_EXP,
  parameter int TAPS    = PRESC_TAPS
)(
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            reset_n,
  // one-cycle tick per divider tap, tap i divides by 2**(LSB_EXP+i)
  output logic [TAPS-1:0]      tap_tick_q
);

  localparam int CW = LSB_EXP + TAPS - 1;

  logic [CW-1:0]   div_q;
  logic [CW-1:0]   div_d;
  logic [TAPS-1:0] tap_tick_d;

  // ----------------------------------------------------------------
  // free-running divider
  // ----------------------------------------------------------------
  always_comb
  begin
    div_d = div_q + {{(CW-1){1'b0}}, 1'b1};
  end

  genvar i;
  generate
    for (i = 0; i < TAPS; i++)
    begin : g_tap
      // ticks when the low bits wrap, so tap i fires once per 2**(LSB_EXP+i) clocks
      assign tap_tick_d[i] = &div_q[LSB_EXP+i-1:0]; // [R3]
    end
  endgenerate

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_q      <= '0;
      tap_tick_q <= '0;
    end
    else
    begin
      div_q      <= div_d;
      tap_tick_q <= tap_tick_d;
    end
  end

endmodule // wd_prescaler
`default_nettype wire

// ---- hdl/wdt_core.sv ----
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module wdt_core
  import wdt_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // asynchronous clock inputs, sampled
  input  wire logic        osc_clk_in,
  input  wire logic        sub_clk_in,
  // chip power mode, same clock domain
  input  wire logic        subactive_mode,
  input  wire logic        standby_mode,
  // internal reset request
  output logic             wd_reset_req
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [2:0]           osc_sync_q, osc_sync_d;
  logic [2:0]           sub_sync_q, sub_sync_d;
  logic [SUB_DIV_W-1:0] sub_div_q, sub_div_d;
  logic                 sub32_tick_q, sub32_tick_d;
  logic                 osc_tick;
  logic [PRESC_TAPS-1:0] tap_tick_q;

  logic       wd_on_q, wd_on_d;
  logic       cwe_q, cwe_d;
  logic [3:0] cks_q, cks_d;
  logic [7:0] ckstp_q, ckstp_d;
  logic [7:0] pmr_q, pmr_d;
  logic [7:0] count_q, count_d;
  logic       ovf_q, ovf_d;
  logic       rst_q, rst_d;
  logic [8:0] rst_cnt_q, rst_cnt_d;
  logic [31:0] prdata_q, prdata_d;
  logic       pready_q, pready_d;
  logic       pslverr_q, pslverr_d;

  logic       src_sub, src_osc, src_presc;
  logic       mode_ok, regs_halt, run_en, cnt_tick;
  logic       acc, wr, wr_csr, wr_cnt, mapped;
  logic [7:0] rd_byte;

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign wd_reset_req = rst_q;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // stage 0 is read only by stage 1; edges are taken from stages 1 and 2
  always_comb
  begin
    osc_sync_d = {osc_sync_q[1:0], osc_clk_in};
    sub_sync_d = {sub_sync_q[1:0], sub_clk_in};
  end

  assign osc_tick = osc_sync_q[1] & ~osc_sync_q[2];

  always_comb
  begin
    sub_div_d    = sub_div_q;
    sub32_tick_d = 1'b0;
    if (sub_sync_q[1] & ~sub_sync_q[2])
    begin
      sub_div_d    = sub_div_q + {{(SUB_DIV_W-1){1'b0}}, 1'b1};
      sub32_tick_d = &sub_div_q;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osc_sync_q   <= '0;
      sub_sync_q   <= '0;
      sub_div_q    <= '0;
      sub32_tick_q <= 1'b0;
    end
    else
    begin
      osc_sync_q   <= osc_sync_d;
      sub_sync_q   <= sub_sync_d;
      sub_div_q    <= sub_div_d;
      sub32_tick_q <= sub32_tick_d;
    end
  end

  wd_prescaler #(
    .LSB_EXP (PRESC_LSB_EXP),
    .TAPS    (PRESC_TAPS)
  ) u_presc (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .tap_tick_q (tap_tick_q)
  );

  // ----------------------------------------------------------------
  // source selection and run conditions
  // ----------------------------------------------------------------
  always_comb
  begin
    src_sub   = pmr_q[PMR_SRC_BIT];                    // [R1]
    src_osc   = ~src_sub & ~cks_q[CKS_TOP_BIT];        // [R2]
    src_presc = ~src_sub & cks_q[CKS_TOP_BIT];
    if (src_sub)
      cnt_tick = sub32_tick_q;                         // [R1]
    else if (src_presc)
      cnt_tick = tap_tick_q[cks_q[2:0]];               // [R2] [R3]
    else
      cnt_tick = osc_tick;                             // [R2]
    if (standby_mode)
      mode_ok = src_osc;                               // [R14]
    else if (subactive_mode)
      mode_ok = src_sub | src_osc;                     // [R13]
    else
      mode_ok = 1'b1;                                  // [R15]
    regs_halt = subactive_mode & src_presc;            // [R13]
    // standby bit only bites once the on bit is clear, and then nothing counts anyway
    run_en = wd_on_q & mode_ok;                        // [R4] [R5]
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  always_comb
  begin
    acc    = psel & penable & pready_q;
    wr     = acc & pwrite;
    wr_csr = wr & (paddr == OFS_CTRL) & ~regs_halt;
    // module standby is in force only with the on bit clear
    wr_cnt = wr & (paddr == OFS_COUNT) & ~regs_halt
             & (ckstp_q[CKSTP_WD_BIT] | wd_on_q);      // [R15]
    mapped = 1'b1;
    unique case (paddr)
      OFS_CTRL:  rd_byte = {cwe_q, 3'h0, 1'b1, wd_on_q, 2'h0};
      OFS_COUNT: rd_byte = count_q;
      OFS_MODE:  rd_byte = {4'h0, cks_q};
      OFS_CKSTP: rd_byte = ckstp_q;
      OFS_PMR:   rd_byte = pmr_q;
      default:
      begin
        rd_byte = 8'h00;
        mapped  = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    // answer in the first access cycle; read data captured at the setup edge
    if (psel & ~penable)
    begin
      pready_d  = 1'b1;
      pslverr_d = ~mapped;
      prdata_d  = {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_comb
  begin
    wd_on_d = wd_on_q;
    cwe_d   = cwe_q;
    cks_d   = cks_q;
    ckstp_d = ckstp_q;
    pmr_d   = pmr_q;
    if (wr_csr)
    begin
      cwe_d = pwdata[CSR_WE_BIT];
      // on bit moves only with write enable already set and inhibit written 0
      if (cwe_q & ~pwdata[CSR_INH_BIT])
        wd_on_d = pwdata[CSR_ON_BIT];                  // [R7] [R8]
    end
    if (wr & (paddr == OFS_MODE) & ~regs_halt)
      cks_d = pwdata[3:0];
    if (wr & (paddr == OFS_CKSTP))
      ckstp_d = (pwdata[7:0] & CKSTP_WMASK) | ~CKSTP_WMASK; // [R4] [R5]
    if (wr & (paddr == OFS_PMR))
      pmr_d = (pwdata[7:0] & PMR_WMASK) | (PMR_RST & ~PMR_WMASK);
  end

  // ----------------------------------------------------------------
  // counter, overflow and reset pulse
  // ----------------------------------------------------------------
  always_comb
  begin
    count_d   = count_q;
    ovf_d     = 1'b0;
    rst_d     = rst_q;
    rst_cnt_d = rst_cnt_q;
    if (wr_cnt)
      count_d = pwdata[7:0];                           // [R12]
    else if (run_en & cnt_tick)
    begin
      count_d = count_q + 8'h01;                       // [R6]
      ovf_d   = (count_q == CNT_MAX);                  // [R10]
    end
    if (ovf_q)
    begin
      rst_d     = 1'b1;                                // [R10]
      rst_cnt_d = '0;
    end
    else if (rst_q & osc_tick)
    begin
      rst_cnt_d = rst_cnt_q + 9'h001;
      if (rst_cnt_q == 9'(RST_OSC_CYCLES - 1))
        rst_d = 1'b0;                                  // [R11]
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wd_on_q   <= CSR_ON_RST;                         // [R9]
      cwe_q     <= CSR_WE_RST;
      cks_q     <= MODE_CKS_RST;                       // [R2]
      ckstp_q   <= CKSTP_RST;                          // [R4]
      pmr_q     <= PMR_RST;
      count_q   <= 8'h00;                              // [R15]
      ovf_q     <= 1'b0;
      rst_q     <= 1'b0;
      rst_cnt_q <= '0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      wd_on_q   <= wd_on_d;
      cwe_q     <= cwe_d;
      cks_q     <= cks_d;
      ckstp_q   <= ckstp_d;
      pmr_q     <= pmr_d;
      count_q   <= count_d;
      ovf_q     <= ovf_d;
      rst_q     <= rst_d;
      rst_cnt_q <= rst_cnt_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_src_sub_tick: assert property (src_sub |-> (cnt_tick == sub32_tick_q)) // [R1]
    else $error("subclock source not routed");
  a_osc_source: assert property (!src_sub && !cks_q[3] |-> (cnt_tick == osc_tick)) // [R2]
    else $error("oscillator source not routed");
  a_tap_source: assert property (!src_sub && cks_q == 4'hC |-> (cnt_tick == tap_tick_q[4])) // [R3]
    else $error("divide by 1024 tap not routed");
  a_standby_deferred: assert property (
    wd_on_q && !ckstp_q[2] && !subactive_mode && !standby_mode |-> run_en) // [R5]
    else $error("standby halted a running watchdog");
  a_count_step: assert property (run_en && cnt_tick && !wr_cnt |=> count_q == $past(count_q) + 8'h01) // [R6]
    else $error("counter did not step");
  a_count_hold: assert property (!run_en && !wr_cnt |=> $stable(count_q)) // [R15]
    else $error("halted counter moved");
  a_start_seq: assert property ($rose(wd_on_q) |-> $past(cwe_q) && $past(wr_csr)) // [R7]
    else $error("watchdog started without enabled write");
  a_ovf_reset: assert property (
    run_en && cnt_tick && !wr_cnt && count_q == 8'hFF |=> ovf_q ##1 rst_q) // [R10]
    else $error("overflow did not raise reset one cycle later");
  a_reset_len: assert property ($fell(rst_q) |-> $past(rst_cnt_q) == 9'h1FF && $past(osc_tick)) // [R11]
    else $error("reset pulse length wrong");
  a_count_load: assert property (wr_cnt |=> count_q == $past(pwdata[7:0])) // [R12]
    else $error("counter load lost");
  a_subactive_halt: assert property (subactive_mode && src_presc |-> !run_en && !wr_csr) // [R13]
    else $error("prescaled source ran in subactive");
  a_standby_osc: assert property (standby_mode && !src_osc |-> !run_en) // [R14]
    else $error("non-oscillator source ran in standby");

  c_overflow:  cover property (ovf_q);
  c_start:     cover property ($rose(wd_on_q));
  c_load:      cover property (wr_cnt);
  c_reset_end: cover property ($fell(rst_q));

endmodule // wdt_core
`default_nettype wire

// ---- testbench/watchdog_counter_with_standby_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module watchdog_counter_with_standby_tb
  import wdt_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        mclk;
  logic        reset_n;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc_clk_in;
  logic        sub_clk_in;
  logic        osc_en;
  logic        subactive_mode;
  logic        standby_mode;
  logic        wd_reset_req;
  int          mismatches;
  int          comparisons;
  logic [31:0] r1;
  logic [31:0] r2;
  logic        e;
  int          n;

  wdt_core dut_u (
    .mclk          (mclk),
    .reset_n       (reset_n),
    .paddr         (paddr),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .osc_clk_in    (osc_clk_in),
    .sub_clk_in    (sub_clk_in),
    .subactive_mode(subactive_mode),
    .standby_mode  (standby_mode),
    .wd_reset_req  (wd_reset_req)
  );

  // ----------------------------------------------------------------
  // clocks: oscillator can be frozen so the counter source can be held still
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    osc_clk_in = 1'b0;
    forever #40 osc_clk_in = osc_en ? ~osc_clk_in : osc_clk_in;
  end
  initial
  begin
    sub_clk_in = 1'b0;
    forever #20 sub_clk_in = ~sub_clk_in;
  end

  // ----------------------------------------------------------------
  // apb master and checks
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no wait limit here: the hang guard ends a transfer that is never answered
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    r   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        err;
    apb(1'b1, a, {24'h0, d}, r, err);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic        err;
    apb(1'b0, a, 32'h0, r, err);
    chk(r, {24'h0, exp});
  endtask

  // read the counter and check it lies in lo..hi
  task automatic rng(input logic [7:0] lo, input logic [7:0] hi);
    logic [31:0] r;
    logic        err;
    apb(1'b0, OFS_COUNT, 32'h0, r, err);
    chk({31'h0, r >= {24'h0, lo} && r <= {24'h0, hi}}, 32'h1);
  endtask

  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard: whole sequence needs roughly 9k cycles
  initial
  begin
    #400000;
    mismatches++;
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    mismatches = 0;
    comparisons = 0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    osc_en = 1'b0;
    subactive_mode = 1'b0;
    standby_mode = 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    rd(OFS_CTRL, 8'h0C);
    rd(OFS_COUNT, 8'h00);
    rd(OFS_MODE, 8'h0F);
    rd(OFS_CKSTP, 8'hFF);
    rd(OFS_PMR, 8'hD8);
    apb(1'b0, 12'h014, 32'h0, r1, e);
    chk(r1, 32'h0);
    chk({31'h0, e}, 32'h1);
    // oscillator selected but frozen: no ticks at all
    wr(OFS_MODE, 8'h05);
    wr(OFS_COUNT, 8'h20);
    repeat (50) @(posedge mclk);
    rd(OFS_COUNT, 8'h20);
    // subclock/32 overrides the mode field
    wr(OFS_PMR, 8'h04);
    rd(OFS_PMR, 8'hDC);
    wr(OFS_COUNT, 8'h00);
    repeat (160) @(posedge mclk);
    rng(8'h01, 8'h02);
    wr(OFS_PMR, 8'h00);
    // clk/1024 tap
    wr(OFS_MODE, 8'h0C);
    wr(OFS_COUNT, 8'h00);
    repeat (1100) @(posedge mclk);
    rng(8'h01, 8'h02);
    // standby halts a prescaler source
    standby_mode <= 1'b1;
    wr(OFS_COUNT, 8'h30);
    repeat (3000) @(posedge mclk);
    rd(OFS_COUNT, 8'h30);
    standby_mode <= 1'b0;
    subactive_mode <= 1'b1;
    wr(OFS_COUNT, 8'h40);
    rd(OFS_COUNT, 8'h30);
    subactive_mode <= 1'b0;
    // standby keeps an oscillator source running
    wr(OFS_MODE, 8'h05);
    osc_en = 1'b1;
    standby_mode <= 1'b1;
    wr(OFS_COUNT, 8'h00);
    repeat (100) @(posedge mclk);
    rng(8'h08, 8'h0D);
    standby_mode <= 1'b0;
    // overflow after one tick, then a 512 oscillator cycle pulse
    wr(OFS_COUNT, 8'hFF);
    n = 0;
    while (wd_reset_req !== 1'b1 && n < 40)
    begin
      @(posedge mclk);
      n++;
    end
    chk({31'h0, n >= 1 && n <= 16}, 32'h1);
    // slow source during the pulse: a second overflow would restart the 512 count
    wr(OFS_MODE, 8'h0F);
    n = 0;
    while (wd_reset_req === 1'b1 && n < 6000)
    begin
      @(posedge mclk);
      n++;
    end
    chk({31'h0, n >= 4080 && n <= 4112}, 32'h1);
    wr(OFS_MODE, 8'h05);
    // standby request stored but ignored while on
    wr(OFS_CKSTP, 8'hFB);
    rd(OFS_CKSTP, 8'hFB);
    wr(OFS_COUNT, 8'h10);
    repeat (100) @(posedge mclk);
    rng(8'h18, 8'h1D);
    // off needs enable first, then a second write
    wr(OFS_CTRL, 8'h80);
    rd(OFS_CTRL, 8'h8C);
    wr(OFS_CTRL, 8'h80);
    rd(OFS_CTRL, 8'h88);
    wr(OFS_COUNT, 8'h10);
    apb(1'b0, OFS_COUNT, 32'h0, r1, e);
    repeat (100) @(posedge mclk);
    apb(1'b0, OFS_COUNT, 32'h0, r2, e);
    chk(r2, r1);
    chk({31'h0, r1 != 32'h10}, 32'h1);
    // start refused without enable or with inhibit set
    wr(OFS_CTRL, 8'h00);
    wr(OFS_CTRL, 8'h04);
    rd(OFS_CTRL, 8'h08);
    wr(OFS_CTRL, 8'h8C);
    rd(OFS_CTRL, 8'h88);
    wr(OFS_CTRL, 8'h8C);
    rd(OFS_CTRL, 8'h88);
    wr(OFS_CTRL, 8'h84);
    rd(OFS_CTRL, 8'h8C);
    apb(1'b0, OFS_COUNT, 32'h0, r1, e);
    repeat (100) @(posedge mclk);
    apb(1'b0, OFS_COUNT, 32'h0, r2, e);
    chk({31'h0, r2 !== r1}, 32'h1);
    final_report();
  end
endmodule // watchdog_counter_with_standby_tb
`default_nettype wire
